// ### fcb_coef_bank.v
`timescale 1ns/1ns
`include "fcb_defs.vh"

module fcb_coef_bank #(
    parameter SAMPLE_W = 12,
    parameter OUT_W    = 36
) (
    // Clock, reset, enable
    input  wire                       core_clk_i,
    input  wire                       srst_i,
    input  wire                       ce_i,
    // AXI4-Lite write address
    input  wire [15:0]                s_axi_awaddr,
    input  wire                       s_axi_awvalid,
    output wire                       s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]                s_axi_wdata,
    input  wire [3:0]                 s_axi_wstrb,
    input  wire                       s_axi_wvalid,
    output wire                       s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]                 s_axi_bresp,
    output reg                        s_axi_bvalid,
    input  wire                       s_axi_bready,
    // AXI4-Lite read address
    input  wire [15:0]                s_axi_araddr,
    input  wire                       s_axi_arvalid,
    output wire                       s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]                s_axi_rdata,
    output reg  [1:0]                 s_axi_rresp,
    output reg                        s_axi_rvalid,
    input  wire                       s_axi_rready,
    // Second-channel samples in, filtered samples out
    input  wire                       sample_valid_i,
    input  wire signed [SAMPLE_W-1:0] sample_i,
    output wire                       filt_valid_o,
    output wire signed [OUT_W-1:0]    filt_o,
    // Mode status
    output wire                       dual_mode_o
);

    // Coefficient storage, full register width including reserved bits
    reg  [`FCB_OUTER_REG_W-1:0]  tap_reg [0:8];
    reg  [`FCB_CENTER_REG_W-1:0] center_reg;
    reg                          dual_reg;

    // Address capture so AW and W may arrive in either order
    reg  [15:0] aw_addr_reg;
    reg         aw_held_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_held_reg;

    wire        do_write;
    reg  [3:0]  wr_sel;
    reg         wr_hit;
    reg  [3:0]  rd_sel;
    reg         rd_hit;
    reg  [31:0] rd_val;
    wire [11:0] wr_idx;
    wire [11:0] rd_idx;
    wire [31:0] wr_mask;
    integer     i;

    // Byte address is four times the printed index
    assign wr_idx = aw_addr_reg[13:2];
    assign rd_idx = s_axi_araddr[13:2];

    // Write channels accept only while their own beat and the response are clear; read only while no read data waits
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

    assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    // Write decode: index to slot, 4 is the centre, 10 is control
    always @* begin
        wr_hit = 1'b1;
        wr_sel = 4'h0;
        if (wr_idx == `FCB_IDX_TAP1) begin
            wr_sel = 4'h0;
        end else if (wr_idx == `FCB_IDX_TAP2) begin
            wr_sel = 4'h1;
        end else if (wr_idx == `FCB_IDX_TAP3) begin
            wr_sel = 4'h2;
        end else if (wr_idx == `FCB_IDX_TAP4) begin
            wr_sel = 4'h3;
        end else if (wr_idx == `FCB_IDX_TAP5) begin
            wr_sel = 4'h4;
        end else if (wr_idx == `FCB_IDX_TAP6) begin
            wr_sel = 4'h5;
        end else if (wr_idx == `FCB_IDX_TAP7) begin
            wr_sel = 4'h6;
        end else if (wr_idx == `FCB_IDX_TAP8) begin
            wr_sel = 4'h7;
        end else if (wr_idx == `FCB_IDX_TAP9) begin
            wr_sel = 4'h8;
        end else if (wr_idx == `FCB_IDX_CTRL) begin
            wr_sel = 4'ha;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Read decode, same map
    always @* begin
        rd_hit = 1'b1;
        rd_sel = 4'h0;
        if (rd_idx == `FCB_IDX_TAP1) begin
            rd_sel = 4'h0;
        end else if (rd_idx == `FCB_IDX_TAP2) begin
            rd_sel = 4'h1;
        end else if (rd_idx == `FCB_IDX_TAP3) begin
            rd_sel = 4'h2;
        end else if (rd_idx == `FCB_IDX_TAP4) begin
            rd_sel = 4'h3;
        end else if (rd_idx == `FCB_IDX_TAP5) begin
            rd_sel = 4'h4;
        end else if (rd_idx == `FCB_IDX_TAP6) begin
            rd_sel = 4'h5;
        end else if (rd_idx == `FCB_IDX_TAP7) begin
            rd_sel = 4'h6;
        end else if (rd_idx == `FCB_IDX_TAP8) begin
            rd_sel = 4'h7;
        end else if (rd_idx == `FCB_IDX_TAP9) begin
            rd_sel = 4'h8;
        end else if (rd_idx == `FCB_IDX_CTRL) begin
            rd_sel = 4'ha;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read value; bits above each register's width read zero
    always @* begin
        rd_val = 32'h00000000;
        if (!rd_hit) begin
            // Unmapped index reads zero, never a stale tap
            rd_val = 32'h00000000;
        end else if (rd_sel == 4'h4) begin
            rd_val = {8'h00, center_reg};
        end else if (rd_sel == 4'ha) begin
            rd_val = {31'h00000000, dual_reg};
        end else if (rd_sel == 4'h8) begin
            // Known readback flaw kept: coefficient MSB always reads zero
            rd_val = {16'h0000, tap_reg[8] & 16'hf7ff};
        end else begin
            rd_val = {16'h0000, tap_reg[rd_sel]};
        end
    end

    // Register file and bus handshake
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            for (i = 0; i < 9; i = i + 1) begin
                tap_reg[i] <= `FCB_RST_OUTER;
            end
            center_reg   <= `FCB_RST_CENTER;
            dual_reg     <= 1'b0;
            aw_addr_reg  <= 16'h0000;
            aw_held_reg  <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FCB_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `FCB_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
            end
            // Tap reserved bits are stored too, they are read/write; control stores bit 0 only
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `FCB_RESP_OKAY : `FCB_RESP_SLVERR;
                if (wr_hit && wr_sel == 4'h4) begin
                    center_reg <= (center_reg & ~wr_mask[23:0]) | (w_data_reg[23:0] & wr_mask[23:0]);
                end else if (wr_hit && wr_sel == 4'ha) begin
                    if (w_strb_reg[0]) begin
                        dual_reg <= w_data_reg[`FCB_CTRL_DUAL_BIT];
                    end
                end else if (wr_hit) begin
                    tap_reg[wr_sel] <= (tap_reg[wr_sel] & ~wr_mask[15:0]) | (w_data_reg[15:0] & wr_mask[15:0]);
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_hit ? `FCB_RESP_OKAY : `FCB_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Sign-extend outer coefficients into one bus, centre taken as is, tap 1 lowest; tap 9 keeps its MSB
    wire [9*18-1:0] coef_bus;
    genvar g;
    generate
        for (g = 0; g < 9; g = g + 1) begin : g_coef
            if (g == `FCB_CENTER_TAP) begin : g_ctr
                assign coef_bus[g*18 +: 18] = center_reg[17:0];
            end else begin : g_out
                assign coef_bus[g*18 +: 18] = {{6{tap_reg[g][11]}}, tap_reg[g][11:0]};
            end
        end
    endgenerate

    assign dual_mode_o = dual_reg;

    // Filter only active in dual channel mode
    fcb_mac #(
        .SAMPLE_W (SAMPLE_W),
        .OUT_W    (OUT_W)
    ) u_mac (
        .core_clk_i     (core_clk_i),
        .srst_i         (srst_i),
        .ce_i           (ce_i),
        .enable_i       (dual_reg),
        .coefs_i        (coef_bus),
        .sample_valid_i (sample_valid_i),
        .sample_i       (sample_i),
        .out_valid_o    (filt_valid_o),
        .out_o          (filt_o)
    );

endmodule

// ### fcb_coef_bank_monitor.sv
`timescale 1ns/1ns
`include "fcb_defs.vh"
// Port-level checks of the coefficient bank
module fcb_monitor (
    // Clock and reset
    input wire        core_clk_i,
    input wire        srst_i,
    input wire        ce_i,
    // Register bus
    input wire [15:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Filter
    input wire        sample_valid_i,
    input wire        filt_valid_o,
    input wire        dual_mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    reg  [11:0] ar_idx_reg;
    // Index of the read in flight decides what its data may hold
    wire c_tap = ar_idx_reg == `FCB_IDX_TAP5;
    wire o_tap = ar_idx_reg inside {`FCB_IDX_TAP1, `FCB_IDX_TAP2, `FCB_IDX_TAP3, `FCB_IDX_TAP4,
                                    `FCB_IDX_TAP6, `FCB_IDX_TAP7, `FCB_IDX_TAP8, `FCB_IDX_TAP9};
    wire mapped = o_tap || c_tap || ar_idx_reg == `FCB_IDX_CTRL;
    sequence s_ar;
        ce_i && s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr;
        ce_i && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Captured on the same edge that raises rvalid; a frozen clock enable takes nothing
    always @(posedge core_clk_i) if (ce_i && s_axi_arvalid && s_axi_arready) ar_idx_reg <= s_axi_araddr[13:2];
    a_read_answer: assert property (s_ar |=> s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (s_wr |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_outer_upper_zero: assert property (s_axi_rvalid && o_tap |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("outer tap upper bits set");
    a_centre_upper_zero: assert property (s_axi_rvalid && c_tap |-> s_axi_rdata[31:24] == 8'h00)
        else $error("centre tap upper bits set");
    a_tap9_msb_zero: assert property (s_axi_rvalid && ar_idx_reg == `FCB_IDX_TAP9 |-> !s_axi_rdata[11])
        else $error("tap 9 sign bit read back");
    a_unmapped_err: assert property (s_axi_rvalid && !mapped |->
        s_axi_rresp == `FCB_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    a_mapped_okay: assert property (s_axi_rvalid && mapped |-> s_axi_rresp == `FCB_RESP_OKAY)
        else $error("mapped read refused");
    a_single_quiet: assert property (!dual_mode_o && !$past(dual_mode_o) |-> !filt_valid_o)
        else $error("filter output in single mode");
    a_filt_cause: assert property (filt_valid_o |-> $past(sample_valid_i))
        else $error("filter output without sample");
endmodule
bind fcb_coef_bank fcb_monitor mon_u (.core_clk_i, .srst_i, .ce_i, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid_i, .filt_valid_o, .dual_mode_o);

// ### fcb_defs.vh
`ifndef FCB_DEFS_VH
`define FCB_DEFS_VH

// Printed register indices (word offsets; the byte address is four times the index)
`define FCB_IDX_TAP1      12'h448
`define FCB_IDX_TAP2      12'h44a
`define FCB_IDX_TAP3      12'h44c
`define FCB_IDX_TAP4      12'h44e
`define FCB_IDX_TAP5      12'h450
`define FCB_IDX_TAP6      12'h453
`define FCB_IDX_TAP7      12'h455
`define FCB_IDX_TAP8      12'h457
`define FCB_IDX_TAP9      12'h459
// Control register index: dual channel enable in bit 0
`define FCB_IDX_CTRL      12'h460
`define FCB_CTRL_DUAL_BIT 0

// Field layout
`define FCB_OUTER_REG_W   16
`define FCB_OUTER_COEF_W  12
`define FCB_CENTER_REG_W  24
`define FCB_CENTER_COEF_W 18
`define FCB_NUM_TAPS      9
`define FCB_CENTER_TAP    4

// Reset values
`define FCB_RST_OUTER     16'h0000
`define FCB_RST_CENTER    24'h000000

// AXI responses
`define FCB_RESP_OKAY     2'b00
`define FCB_RESP_SLVERR   2'b10

`endif

// ### fcb_mac.v
`timescale 1ns/1ns
`include "fcb_defs.vh"

// Nine-tap sum of products, one registered output per enabled sample
module fcb_mac #(
    parameter SAMPLE_W = 12,
    parameter OUT_W    = 36
) (
    // Clock and control
    input  wire                       core_clk_i,
    input  wire                       srst_i,
    input  wire                       ce_i,
    input  wire                       enable_i,
    // Coefficients, tap 1 in the low slice, all 18 bits wide, outer taps sign-extended
    input  wire [9*18-1:0]            coefs_i,
    // Samples
    input  wire                       sample_valid_i,
    input  wire signed [SAMPLE_W-1:0] sample_i,
    output reg                        out_valid_o,
    output reg  signed [OUT_W-1:0]    out_o
);

    reg signed [SAMPLE_W-1:0] delay_reg [0:7];
    reg signed [OUT_W-1:0]    acc;
    integer                   k;
    integer                   s;

    // Newest sample meets tap 1 straight from the input, so the sum is ready on the shift edge
    always @* begin
        acc = $signed(coefs_i[17:0]) * sample_i;
        for (k = 1; k < 9; k = k + 1) begin
            acc = acc + $signed(coefs_i[k*18 +: 18]) * delay_reg[k-1];
        end
    end

    // Delay line and output register
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            for (s = 0; s < 8; s = s + 1) begin
                delay_reg[s] <= {SAMPLE_W{1'b0}};
            end
            out_valid_o <= 1'b0;
            out_o       <= {OUT_W{1'b0}};
        end else if (ce_i) begin
            out_valid_o <= enable_i && sample_valid_i;
            if (sample_valid_i) begin
                delay_reg[0] <= sample_i;
                for (s = 1; s < 8; s = s + 1) begin
                    delay_reg[s] <= delay_reg[s-1];
                end
            end
            // Sum is latched with its valid so both stand in the same cycle
            if (enable_i && sample_valid_i) begin
                out_o <= acc;
            end else if (!enable_i) begin
                out_o <= {OUT_W{1'b0}};
            end
        end
    end

endmodule

// ### fir_channel_b_coefficient_bank_test.sv
`timescale 1ns/1ns
`include "fcb_defs.vh"
// Register readback, refusals and filter arithmetic
module fir_channel_b_coefficient_bank_test;
    reg                core_clk_i = 1'h0;
    reg                srst_i = 1'h1;
    reg                ce_i = 1'h1;
    reg         [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    reg         [31:0] s_axi_wdata = 32'h0;
    reg         [3:0]  s_axi_wstrb = 4'hf;
    reg                s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg                s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sample_valid_i = 1'h0;
    reg  signed [11:0] sample_i = 12'h0;
    wire               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire               filt_valid_o, dual_mode_o;
    wire        [1:0]  s_axi_bresp, s_axi_rresp;
    wire        [31:0] s_axi_rdata;
    wire signed [35:0] filt_o;
    int                fails = 0, n_compared = 0, n;
    logic       [11:0] idx [9] = '{`FCB_IDX_TAP1, `FCB_IDX_TAP2, `FCB_IDX_TAP3, `FCB_IDX_TAP4, `FCB_IDX_TAP5,
                                   `FCB_IDX_TAP6, `FCB_IDX_TAP7, `FCB_IDX_TAP8, `FCB_IDX_TAP9};
    logic signed [17:0] cf [9];
    logic signed [11:0] hist [9];
    localparam [15:0] CA = {2'h0, `FCB_IDX_CTRL, 2'h0};
    // Hole between the centre tap and tap 6
    localparam [15:0] UA = {2'h0, 12'h451, 2'h0};
    fcb_coef_bank dut_u (.core_clk_i, .srst_i, .ce_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sample_valid_i, .sample_i, .filt_valid_o, .filt_o, .dual_mode_o);
    initial forever #5 core_clk_i = ~core_clk_i;
    function automatic [15:0] ta(input int i);
        ta = {2'h0, idx[i], 2'h0};
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Every wait is bounded so a dead handshake ends the run
    task automatic step;
        @(posedge core_clk_i);
        n++;
        if (n > 60) begin
            fails++;
            $display("BAD %0t timeout", $time);
            finish_test;
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axw(input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw && w)) begin
            step;
            aw |= s_axi_awvalid && s_axi_awready;
            w |= s_axi_wvalid && s_axi_wready;
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1) step;
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        @(posedge core_clk_i);
    endtask
    task automatic axr(input [15:0] a, input [31:0] ed, input [1:0] er);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do step; while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do step; while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        @(posedge core_clk_i);
    endtask
    // Mode 0 expects silence, 1 waits for output, 2 also checks the sum
    task automatic smp(input logic signed [11:0] x, input int m);
        logic signed [35:0] e;
        e = 0;
        n = 0;
        for (int k = 8; k > 0; k--) hist[k] = hist[k-1];
        hist[0] = x;
        for (int k = 0; k < 9; k++) e += cf[k] * hist[k];
        sample_i <= x;
        sample_valid_i <= 1'h1;
        step;
        sample_valid_i <= 1'h0;
        if (m == 0) repeat (3) begin
            step;
            chk(filt_valid_o, 36'h0);
        end else begin
            do step; while (filt_valid_o !== 1'h1);
            if (m == 2) chk(filt_o, e);
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'h0;
        @(posedge core_clk_i);
        for (int i = 0; i < 9; i++) axr(ta(i), 32'h0, `FCB_RESP_OKAY);
        axr(CA, 32'h0, `FCB_RESP_OKAY);
        // Reserved bits are storage; tap 9 hides its sign bit
        for (int i = 0; i < 9; i++) begin
            axw(ta(i), 32'hffffffff, 4'hf, `FCB_RESP_OKAY);
            axr(ta(i), i == 4 ? 32'hffffff : i == 8 ? 32'hf7ff : 32'hffff, `FCB_RESP_OKAY);
        end
        axw(UA, 32'h1, 4'hf, `FCB_RESP_SLVERR);
        axr(UA, 32'h0, `FCB_RESP_SLVERR);
        axw(ta(0), 32'h0, 4'h1, `FCB_RESP_OKAY);
        axr(ta(0), 32'hff00, `FCB_RESP_OKAY);
        // Extreme centre and tap 9 values stress the product widths
        for (int i = 0; i < 9; i++) begin
            cf[i] = i + 1;
            hist[i] = 12'h0;
        end
        cf[4] = 18'h20001;
        cf[8] = 18'h3f801;
        for (int i = 0; i < 9; i++) axw(ta(i), {14'h0, cf[i]}, 4'hf, `FCB_RESP_OKAY);
        smp(12'h123, 0);
        axw(CA, 32'h1, 4'hf, `FCB_RESP_OKAY);
        chk(dual_mode_o, 36'h1);
        // History starts from reset zeros and shifts in single mode too, so every sum is known
        for (int j = 0; j < 20; j++) smp(j[0] ? 12'h800 + j : 12'h7ff - j, 2);
        // Clock enable low freezes the delay line and the output
        ce_i <= 1'h0;
        sample_valid_i <= 1'h1;
        sample_i <= 12'h555;
        repeat (3) begin
            @(posedge core_clk_i);
            chk(filt_valid_o, 36'h0);
        end
        ce_i <= 1'h1;
        sample_valid_i <= 1'h0;
        @(posedge core_clk_i);
        smp(12'h321, 2);
        // Reset in mid-run clears coefficients and mode
        srst_i <= 1'h1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'h0;
        @(posedge core_clk_i);
        axr(ta(8), 32'h0, `FCB_RESP_OKAY);
        axr(ta(4), 32'h0, `FCB_RESP_OKAY);
        chk(dual_mode_o, 36'h0);
        finish_test;
    end
endmodule
